// ### l2_fwd_pkg.sv
`default_nettype none
package l2_fwd_pkg;
	// ****************************************************************
	// Widths of addresses, VLAN identifiers and IP addresses.
	// ****************************************************************
	localparam int MAC_W = 48;
	localparam int VID_W = 12;
	localparam int IP_W = 32;
	localparam int NUM_IP = 5;
	localparam int ABIL_W = 5;
	localparam int ID_W = 8;
	// ****************************************************************
	// Register byte offsets.
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_KEY_LO = 8'h08;
	localparam logic [7:0] ADDR_KEY_HI = 8'h0C;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_FWD_CNT = 8'h14;
	localparam logic [7:0] ADDR_DROP_CNT = 8'h18;
	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int CTRL_SEC_BIT = 0;
	localparam int CTRL_VLAN_BIT = 1;
	localparam int CTRL_ABIL_LSB = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000007C;
	localparam int KEY_VID_LSB = 16;
	localparam int CMD_IDX_LSB = 2;
	localparam int CMD_PORT_LSB = 5;
	localparam int CMD_ADD_BIT = 10;
	localparam int ABIL_10H = 0;
	localparam int ABIL_10F = 1;
	localparam int ABIL_100H = 2;
	localparam int ABIL_100F = 3;
	localparam int ABIL_1000F = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************************************
	// Enumerations.
	// ****************************************************************
	typedef enum logic [1:0] {KIND_STATIC, KIND_FILTER, KIND_IP}
		table_kind_type;
	typedef enum logic [2:0] {NEG_NONE, NEG_10H, NEG_10F, NEG_100H,
		NEG_100F, NEG_1000F} neg_mode_type;
endpackage
`default_nettype wire

// ### l2_address_table_forwarder.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module l2_address_table_forwarder #(
	parameter int NUM_PORTS  = 26,
	parameter int NUM_LEARN  = 16,
	parameter int NUM_STATIC = 8,
	parameter int NUM_FILTER = 8,
	parameter int PORT_W     = $clog2(NUM_PORTS)
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic [7:0]                     s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [7:0]                     s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic                           rxValid,
	output logic                                rxReady,
	input  wire logic [l2_fwd_pkg::MAC_W-1:0]   rxDstMac,
	input  wire logic [l2_fwd_pkg::MAC_W-1:0]   rxSrcMac,
	input  wire logic [l2_fwd_pkg::VID_W-1:0]   rxVid,
	input  wire logic [PORT_W-1:0]              rxPort,
	input  wire logic                           rxFrameOk,
	input  wire logic [l2_fwd_pkg::ID_W-1:0]    rxFrameId,
	output logic                                txValid,
	input  wire logic                           txReady,
	output logic [NUM_PORTS-1:0]                txMask,
	output logic [l2_fwd_pkg::ID_W-1:0]         txFrameId,
	input  wire logic                           mgmtValid,
	input  wire logic [l2_fwd_pkg::IP_W-1:0]    mgmtSrcIp,
	output logic                                mgmtDone,
	output logic                                mgmtAllow,
	input  wire logic                           linkUp,
	input  wire logic [l2_fwd_pkg::ABIL_W-1:0]  partnerAbil,
	output l2_fwd_pkg::neg_mode_type            negMode
);
	import l2_fwd_pkg::*;
	localparam int LIW = $clog2(NUM_LEARN);
	localparam logic [NUM_PORTS-1:0] ALL_PORTS = '1;

	// ****************************************************************
	// Key match, byte-lane merge and speed resolution.
	// ****************************************************************
	function automatic logic keyMatch(input logic [MAC_W-1:0] a,
		input logic [MAC_W-1:0] b, input logic [VID_W-1:0] va,
		input logic [VID_W-1:0] vb, input logic useVid);
		return (a == b) && (!useVid || va == vb);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction
	// Half-duplex gigabit is not offered, so it can never be chosen.
	function automatic neg_mode_type bestMode(input logic [ABIL_W-1:0] c);
		if (c[ABIL_1000F]) return NEG_1000F;
		else if (c[ABIL_100F]) return NEG_100F;
		else if (c[ABIL_100H]) return NEG_100H;
		else if (c[ABIL_10F]) return NEG_10F;
		else if (c[ABIL_10H]) return NEG_10H;
		else return NEG_NONE;
	endfunction

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic [31:0]      ctrl_reg;               // Mode and ability bits.
	logic [31:0]      keyLo_reg, keyHi_reg;   // Staged table key.
	logic [31:0]      fwdCnt_reg, dropCnt_reg;// Frame counters.
	logic             awready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0]       bresp_reg, rresp_reg;   // Bus answers.
	logic [31:0]      rdata_reg;              // Read data.
	wire              secEnable = ctrl_reg[CTRL_SEC_BIT];
	wire              vlanAware = ctrl_reg[CTRL_VLAN_BIT];
	wire [ABIL_W-1:0] localAbil = ctrl_reg[CTRL_ABIL_LSB +: ABIL_W];
	// Static, filter and allow-list tables.
	logic [MAC_W-1:0] stMac_reg [NUM_STATIC];
	logic [VID_W-1:0] stVid_reg [NUM_STATIC];
	logic [PORT_W-1:0] stPort_reg [NUM_STATIC];
	logic [NUM_STATIC-1:0] stValid_reg;
	logic [MAC_W-1:0] ftMac_reg [NUM_FILTER];
	logic [VID_W-1:0] ftVid_reg [NUM_FILTER];
	logic [NUM_FILTER-1:0] ftValid_reg;
	logic [IP_W-1:0]  ip_reg [NUM_IP];
	logic [NUM_IP-1:0] ipValid_reg;
	// Learned table.
	logic [MAC_W-1:0] lrnMac_reg [NUM_LEARN];
	logic [VID_W-1:0] lrnVid_reg [NUM_LEARN];
	logic [PORT_W-1:0] lrnPort_reg [NUM_LEARN];
	logic [NUM_LEARN-1:0] lrnValid_reg;
	logic [LIW-1:0]   rrPtr_reg;              // Replacement pointer.

	// ****************************************************************
	// Bus handshakes and decoding.
	// ****************************************************************
	wire wrFire = s_axi_awvalid && s_axi_wvalid && !awready_reg
		&& !bvalid_reg;
	wire wrTake = awready_reg;
	wire rdFire = s_axi_arvalid && !arready_reg && !rvalid_reg;
	wire wrCtrl = wrTake && s_axi_awaddr == ADDR_CTRL;
	wire wrKeyLo = wrTake && s_axi_awaddr == ADDR_KEY_LO;
	wire wrKeyHi = wrTake && s_axi_awaddr == ADDR_KEY_HI;
	wire wrCmd = wrTake && s_axi_awaddr == ADDR_CMD;
	wire wrOk = wrCtrl || wrKeyLo || wrKeyHi || wrCmd;
	wire [31:0] cmdWord = merge(32'h00000000, s_axi_wdata, s_axi_wstrb);
	wire [1:0] cmdKind = cmdWord[1:0];
	wire [2:0] cmdIdx = cmdWord[CMD_IDX_LSB +: 3];
	wire [PORT_W-1:0] cmdPort = cmdWord[CMD_PORT_LSB +: PORT_W];
	wire cmdAdd = cmdWord[CMD_ADD_BIT];
	wire [MAC_W-1:0] keyMac = {keyHi_reg[15:0], keyLo_reg};
	wire [VID_W-1:0] keyVid = keyHi_reg[KEY_VID_LSB +: VID_W];
	logic [31:0] rdMux;
	logic rdOk;
	always_comb begin
		rdOk = 1'b1;
		if (s_axi_araddr == ADDR_CTRL) rdMux = ctrl_reg;
		else if (s_axi_araddr == ADDR_STATUS)
			rdMux = {29'h00000000, negMode};
		else if (s_axi_araddr == ADDR_KEY_LO) rdMux = keyLo_reg;
		else if (s_axi_araddr == ADDR_KEY_HI) rdMux = keyHi_reg;
		else if (s_axi_araddr == ADDR_FWD_CNT) rdMux = fwdCnt_reg;
		else if (s_axi_araddr == ADDR_DROP_CNT) rdMux = dropCnt_reg;
		else begin
			// Unmapped or write-only offsets answer with an error.
			rdMux = 32'h00000000;
			rdOk = 1'b0;
		end
	end

	// Write channel: address and data are taken together.
	always_ff @(posedge clk) begin
		awready_reg <= !rst && wrFire;
		if (rst) bvalid_reg <= 1'b0;
		else if (wrTake) bvalid_reg <= 1'b1;
		else if (s_axi_bready) bvalid_reg <= 1'b0;
		if (rst) bresp_reg <= RESP_OKAY;
		else if (wrTake) bresp_reg <= wrOk ? RESP_OKAY : RESP_SLVERR;
	end
	// Read channel: data follow the address by one cycle.
	always_ff @(posedge clk) begin
		arready_reg <= !rst && rdFire;
		if (rst) rvalid_reg <= 1'b0;
		else if (arready_reg) rvalid_reg <= 1'b1;
		else if (s_axi_rready) rvalid_reg <= 1'b0;
		if (rst) begin
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (arready_reg) begin
			rdata_reg <= rdMux;
			rresp_reg <= rdOk ? RESP_OKAY : RESP_SLVERR;
		end
	end
	// Plain registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
			keyLo_reg <= 32'h00000000;
			keyHi_reg <= 32'h00000000;
		end else begin
			if (wrCtrl) ctrl_reg <= merge(ctrl_reg, s_axi_wdata, s_axi_wstrb);
			if (wrKeyLo) keyLo_reg <= merge(keyLo_reg, s_axi_wdata, s_axi_wstrb);
			if (wrKeyHi) keyHi_reg <= merge(keyHi_reg, s_axi_wdata, s_axi_wstrb);
		end
	end
	// Table commands add or delete one entry from the staged key.
	always_ff @(posedge clk) begin
		if (rst) begin
			stValid_reg <= '0;
			ftValid_reg <= '0;
			ipValid_reg <= '0;
		end else if (wrCmd) begin
			if (cmdKind == KIND_STATIC && 32'(cmdIdx) < NUM_STATIC) begin
				stValid_reg[cmdIdx] <= cmdAdd;
				stMac_reg[cmdIdx] <= keyMac;
				stVid_reg[cmdIdx] <= keyVid;
				stPort_reg[cmdIdx] <= cmdPort;
			end else if (cmdKind == KIND_FILTER
				&& 32'(cmdIdx) < NUM_FILTER) begin
				ftValid_reg[cmdIdx] <= cmdAdd;
				ftMac_reg[cmdIdx] <= keyMac;
				ftVid_reg[cmdIdx] <= keyVid;
			end else if (cmdKind == KIND_IP && 32'(cmdIdx) < NUM_IP) begin
				ipValid_reg[cmdIdx] <= cmdAdd;
				ip_reg[cmdIdx] <= keyLo_reg;
			end
		end
	end

	// ****************************************************************
	// Address lookup.
	// ****************************************************************
	logic dstHit, srcStatic, srcLrnHit, filterHit;
	logic [PORT_W-1:0] dstPort;
	logic [LIW-1:0] srcLrnIdx;
	always_comb begin
		dstHit = 1'b0;
		dstPort = '0;
		srcStatic = 1'b0;
		srcLrnHit = 1'b0;
		srcLrnIdx = '0;
		filterHit = 1'b0;
		for (int i = 0; i < NUM_LEARN; i++) begin
			if (lrnValid_reg[i] && keyMatch(lrnMac_reg[i], rxDstMac,
				lrnVid_reg[i], rxVid, vlanAware)) begin
				dstHit = 1'b1;
				dstPort = lrnPort_reg[i];
			end
			if (lrnValid_reg[i] && keyMatch(lrnMac_reg[i], rxSrcMac,
				lrnVid_reg[i], rxVid, vlanAware)) begin
				srcLrnHit = 1'b1;
				srcLrnIdx = LIW'(i);
			end
		end
		// Statics are searched last so that they win over learned ones.
		for (int i = 0; i < NUM_STATIC; i++) begin
			if (stValid_reg[i] && keyMatch(stMac_reg[i], rxDstMac,
				stVid_reg[i], rxVid, vlanAware)) begin
				dstHit = 1'b1;
				dstPort = stPort_reg[i];
			end
			if (stValid_reg[i] && keyMatch(stMac_reg[i], rxSrcMac,
				stVid_reg[i], rxVid, vlanAware)) srcStatic = 1'b1;
		end
		for (int i = 0; i < NUM_FILTER; i++) begin
			if (ftValid_reg[i] && keyMatch(ftMac_reg[i], rxDstMac,
				ftVid_reg[i], rxVid, vlanAware)) filterHit = 1'b1;
		end
	end

	// ****************************************************************
	// Forwarding decision and two-entry output buffer.
	// ****************************************************************
	logic [1:0] cnt_reg;
	logic [NUM_PORTS-1:0] spareMask_reg;
	logic [ID_W-1:0] spareId_reg;
	logic rxReady_reg, txValid_reg;
	logic [NUM_PORTS-1:0] txMask_reg;
	logic [ID_W-1:0] txFrameId_reg;
	wire take = rxValid && rxReady_reg;
	wire [NUM_PORTS-1:0] inBit = NUM_PORTS'(1) << rxPort;
	wire [NUM_PORTS-1:0] dstBit = NUM_PORTS'(1) << dstPort;
	wire samePort = dstHit && dstPort == rxPort;
	// Errored and filtered frames are discarded before any decision.
	wire sendOk = rxFrameOk && !filterHit && !samePort;
	wire [NUM_PORTS-1:0] newMask = dstHit ? dstBit
		: (ALL_PORTS & ~inBit);
	wire push = take && sendOk;
	wire pop = txValid_reg && txReady;
	wire [1:0] cntNext = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
	// Head slot drives the outputs; the spare slot absorbs a stall.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 2'h0;
			rxReady_reg <= 1'b0;
			txValid_reg <= 1'b0;
			txMask_reg <= '0;
			txFrameId_reg <= '0;
			spareMask_reg <= '0;
			spareId_reg <= '0;
		end else begin
			cnt_reg <= cntNext;
			rxReady_reg <= cntNext != 2'h2;
			txValid_reg <= cntNext != 2'h0;
			if (pop && cnt_reg == 2'h2) begin
				txMask_reg <= spareMask_reg;
				txFrameId_reg <= spareId_reg;
			end else if (push && (cnt_reg == 2'h0 || pop)) begin
				txMask_reg <= newMask;
				txFrameId_reg <= rxFrameId;
			end
			if (push && cnt_reg != 2'h0 && !(pop && cnt_reg == 2'h1)) begin
				spareMask_reg <= newMask;
				spareId_reg <= rxFrameId;
			end
		end
	end
	// Counters of sent and discarded frames.
	always_ff @(posedge clk) begin
		if (rst) begin
			fwdCnt_reg <= 32'h00000000;
			dropCnt_reg <= 32'h00000000;
		end else begin
			if (push) fwdCnt_reg <= fwdCnt_reg + 32'h00000001;
			if (take && !sendOk) dropCnt_reg <= dropCnt_reg + 32'h00000001;
		end
	end

	// ****************************************************************
	// Source learning.
	// ****************************************************************
	wire learnWr = take && !srcStatic;
	wire [LIW-1:0] learnIdx = srcLrnHit ? srcLrnIdx : rrPtr_reg;
	always_ff @(posedge clk) begin
		if (rst) rrPtr_reg <= '0;
		else if (learnWr && !srcLrnHit) rrPtr_reg <= LIW'(rrPtr_reg + 1'b1);
	end
	for (genvar g = 0; g < NUM_LEARN; g++) begin : gLearn
		// Each entry records source address, VLAN and ingress port.
		always_ff @(posedge clk) begin
			if (rst) lrnValid_reg[g] <= 1'b0;
			else if (learnWr && learnIdx == LIW'(g)) begin
				lrnValid_reg[g] <= 1'b1;
				lrnMac_reg[g] <= rxSrcMac;
				lrnVid_reg[g] <= rxVid;
				lrnPort_reg[g] <= rxPort;
			end
		end
	end

	// ****************************************************************
	// Management allow-list and link resolution.
	// ****************************************************************
	logic ipHit;
	always_comb begin
		ipHit = 1'b0;
		for (int i = 0; i < NUM_IP; i++) begin
			if (ipValid_reg[i] && ip_reg[i] == mgmtSrcIp) ipHit = 1'b1;
		end
	end
	logic mgmtDone_reg, mgmtAllow_reg;
	always_ff @(posedge clk) begin
		mgmtDone_reg <= !rst && mgmtValid;
		mgmtAllow_reg <= !rst && mgmtValid && (!secEnable || ipHit);
	end
	logic linkMeta_reg, linkSync_reg, linkPrev_reg;
	logic [ABIL_W-1:0] abilMeta_reg, abilSync_reg;
	neg_mode_type negMode_reg;
	wire neg_mode_type negBest = bestMode(localAbil & abilSync_reg);
	// Pins pass two flip-flops; the mode settles on link rise.
	always_ff @(posedge clk) begin
		if (rst) begin
			{linkMeta_reg, linkSync_reg, linkPrev_reg} <= 3'h0;
			abilMeta_reg <= '0;
			abilSync_reg <= '0;
			negMode_reg <= NEG_NONE;
		end else begin
			{linkMeta_reg, linkSync_reg, linkPrev_reg} <=
				{linkUp, linkMeta_reg, linkSync_reg};
			abilMeta_reg <= partnerAbil;
			abilSync_reg <= abilMeta_reg;
			if (!linkSync_reg) negMode_reg <= NEG_NONE;
			else if (!linkPrev_reg) negMode_reg <= negBest;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = awready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign rxReady = rxReady_reg;
	assign txValid = txValid_reg;
	assign txMask = txMask_reg;
	assign txFrameId = txFrameId_reg;
	assign mgmtDone = mgmtDone_reg;
	assign mgmtAllow = mgmtAllow_reg;
	assign negMode = negMode_reg;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// An errored frame must bump the drop count and leave the sent count.
	a_error_drop: assert property (take && !rxFrameOk
		|=> fwdCnt_reg == $past(fwdCnt_reg)
		&& dropCnt_reg == $past(dropCnt_reg) + 32'h00000001)
		else $error("Errored frame was queued.");
	a_filter_drop: assert property (take && filterHit
		|=> $past(dropCnt_reg) + 32'h00000001 == dropCnt_reg)
		else $error("Filtered frame not dropped.");
	a_flood_mask: assert property (push && !dstHit && cnt_reg == 2'h0
		|=> txValid && txMask == (ALL_PORTS & ~$past(inBit)))
		else $error("Flood mask wrong.");
	a_unicast_mask: assert property (push && dstHit && cnt_reg == 2'h0
		|=> txMask == $past(dstBit) && $onehot(txMask))
		else $error("Unicast mask wrong.");
	a_same_drop: assert property (take && samePort
		|=> fwdCnt_reg == $past(fwdCnt_reg))
		else $error("Same-port frame queued.");
	a_learn_write: assert property (learnWr
		|=> lrnValid_reg[$past(learnIdx)]
		&& lrnMac_reg[$past(learnIdx)] == $past(rxSrcMac))
		else $error("Source not learned.");
	a_static_kept: assert property (!wrCmd
		|=> stValid_reg == $past(stValid_reg))
		else $error("Static entry changed without command.");
	a_ip_gate: assert property (mgmtValid && secEnable && !ipHit
		|=> mgmtDone && !mgmtAllow)
		else $error("Unlisted source allowed.");
	a_gig_full: assert property (negMode == NEG_1000F
		|-> localAbil[ABIL_1000F] && abilSync_reg[ABIL_1000F])
		else $error("Gigabit chosen without full duplex.");
	a_neg_best: assert property (linkSync_reg && !linkPrev_reg
		|=> negMode == $past(negBest))
		else $error("Link mode not resolved.");
	c_flood: cover property (push && !dstHit);
	c_stall_full: cover property (cnt_reg == 2'h2 && !txReady);
	c_filter: cover property (take && filterHit && dstHit);
endmodule // l2_address_table_forwarder
`default_nettype wire

// ### eth_port_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Station model that receives what the forwarder sends out.
// ****************************************************************
module eth_port_sink #(
	parameter int NUM_PORTS = 26
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 stall,
	input  wire logic                 txValid,
	output logic                      txReady,
	input  wire logic [NUM_PORTS-1:0] txMask,
	input  wire logic [7:0]           txFrameId,
	output logic [NUM_PORTS-1:0]      lastMask,
	output logic [7:0]                lastId,
	output logic [15:0]               gotCount
);
	// A stalled station refuses, so the forwarder must hold its entry.
	assign txReady = !stall;
	// Each entry is recorded once, at the edge where it is handed over.
	always_ff @(posedge clk) begin
		if (rst) begin
			gotCount <= 16'h0;
			lastMask <= '0;
			lastId <= 8'h0;
		end else if (txValid && txReady) begin
			gotCount <= gotCount + 16'h1;
			lastMask <= txMask;
			lastId <= txFrameId;
		end
	end
endmodule // eth_port_sink
`default_nettype wire

// ### l2_address_table_forwarder_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the forwarding engine.
// ****************************************************************
module l2_address_table_forwarder_tb;
	import l2_fwd_pkg::*;
	typedef struct {logic [47:0] dst, src; logic [4:0] port;
		logic ok, sent; logic [25:0] mask;} row_type;
	logic clk, rst, awValid, wValid, bRdy, arValid, rRdy, stall;
	logic awRdy, wRdy, bValid, arRdy, rValid, txValid, txReady;
	logic rxValid, rxReady, rxFrameOk, mgmtValid, mgmtDone, mgmtAllow;
	logic linkUp;
	logic [7:0] awAddr, arAddr, rxFrameId, lastId;
	logic [11:0] rxVid;
	logic [31:0] wData, rData, mgmtSrcIp;
	logic [1:0] bResp, rResp;
	logic [47:0] rxDstMac, rxSrcMac;
	logic [4:0] rxPort, partnerAbil;
	logic [25:0] txMask, lastMask;
	logic [7:0] txFrameId;
	logic [15:0] gotCount, n;
	neg_mode_type negMode;
	row_type rows[5];
	int errCount = 0, checksDone = 0, cycles = 0;
	// The clock toggles every half period of 4 ns.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	l2_address_table_forwarder i_l2_address_table_forwarder (.clk(clk),
		.rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bRdy), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arRdy), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rRdy),
		.rxValid(rxValid), .rxReady(rxReady), .rxDstMac(rxDstMac),
		.rxSrcMac(rxSrcMac), .rxVid(rxVid), .rxPort(rxPort),
		.rxFrameOk(rxFrameOk), .rxFrameId(rxFrameId), .txValid(txValid),
		.txReady(txReady), .txMask(txMask), .txFrameId(txFrameId),
		.mgmtValid(mgmtValid), .mgmtSrcIp(mgmtSrcIp), .mgmtDone(mgmtDone),
		.mgmtAllow(mgmtAllow), .linkUp(linkUp), .partnerAbil(partnerAbil),
		.negMode(negMode));
	eth_port_sink i_eth_port_sink (.clk(clk), .rst(rst), .stall(stall),
		.txValid(txValid), .txReady(txReady), .txMask(txMask),
		.txFrameId(txFrameId), .lastMask(lastMask), .lastId(lastId),
		.gotCount(gotCount));
	// Prints the verdict and ends the run.
	task automatic endOfTest;
		if (errCount == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Compares a seen value with the expected one.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Register write: address and data together, then the response.
	task automatic axWr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] resp);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		do @(posedge clk); while (awRdy !== 1'b1);
		chk(wRdy, 1'b1);
		awValid <= 1'b0;
		wValid <= 1'b0;
		bRdy <= 1'b1;
		do @(posedge clk); while (bValid !== 1'b1);
		bRdy <= 1'b0;
		chk(bResp, resp);
	endtask
	// Register read, checking data and response code.
	task automatic axRd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] resp);
		arAddr <= a;
		arValid <= 1'b1;
		do @(posedge clk); while (arRdy !== 1'b1);
		arValid <= 1'b0;
		rRdy <= 1'b1;
		do @(posedge clk); while (rValid !== 1'b1);
		rRdy <= 1'b0;
		chk(rData, d);
		chk(rResp, resp);
	endtask
	// Offers one frame descriptor and holds it until it is taken.
	task automatic sendFrame(input logic [47:0] d, s, input logic [4:0] p,
		input logic ok);
		rxDstMac <= d;
		rxSrcMac <= s;
		rxPort <= p;
		rxFrameOk <= ok;
		rxFrameId <= rxFrameId + 8'h01;
		rxValid <= 1'b1;
		do @(posedge clk); while (rxReady !== 1'b1);
		rxValid <= 1'b0;
		@(posedge clk);
	endtask
	// One management request; the answer stands in the next cycle only.
	task automatic askMgmt(input logic [31:0] ip, input logic allow);
		mgmtSrcIp <= ip;
		mgmtValid <= 1'b1;
		@(posedge clk);
		mgmtValid <= 1'b0;
		#1;
		chk({mgmtDone, mgmtAllow}, {1'b1, allow});
		@(posedge clk);
	endtask
	// Drops the link, then raises it with a new partner ability set.
	task automatic link(input logic [4:0] ab, input neg_mode_type m);
		linkUp <= 1'b0;
		repeat (6) @(posedge clk);
		partnerAbil <= ab;
		linkUp <= 1'b1;
		repeat (6) @(posedge clk);
		chk(negMode, m);
	endtask
	// A hang ends the run as a mismatch.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errCount++;
			endOfTest();
		end
	end
	// Main sequence: reset, table of frames, then the awkward cases.
	initial begin
		{rst, awValid, wValid, bRdy, arValid, rRdy, rxValid} = 7'h7F;
		{awValid, wValid, bRdy, arValid, rRdy, rxValid, stall} = 7'h0;
		{rxFrameOk, mgmtValid, linkUp, awAddr, arAddr, rxFrameId, rxVid} = '0;
		{wData, mgmtSrcIp, rxDstMac, rxSrcMac, rxPort, partnerAbil} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Values seen here were set at the first edge after release.
		repeat (2) @(posedge clk);
		chk({txValid, negMode, rxReady, bValid, rValid},
			{1'b0, NEG_NONE, 1'b1, 1'b0, 1'b0});
		axRd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
		axRd(8'h20, 32'h0, RESP_SLVERR);
		axWr(ADDR_FWD_CNT, 32'h1, RESP_SLVERR);
		rows[0] = '{48'h0B1, 48'h0A1, 5'd3, 1'b1, 1'b1, 26'h3FFFFF7};
		rows[1] = '{48'h0A1, 48'h0B1, 5'd7, 1'b1, 1'b1, 26'h8};
		rows[2] = '{48'h0A1, 48'h0C1, 5'd3, 1'b1, 1'b0, 26'h8};
		rows[3] = '{48'h0C1, 48'h0B1, 5'd7, 1'b0, 1'b0, 26'h8};
		rows[4] = '{48'h0C1, 48'h0A1, 5'd5, 1'b1, 1'b1, 26'h8};
		foreach (rows[i]) begin
			n = gotCount;
			sendFrame(rows[i].dst, rows[i].src, rows[i].port, rows[i].ok);
			repeat (3) @(posedge clk);
			chk(gotCount - n, rows[i].sent);
			chk(lastMask, rows[i].mask);
		end
		axWr(ADDR_KEY_LO, 32'h5A, RESP_OKAY);
		axWr(ADDR_CMD, 32'h520, RESP_OKAY);
		sendFrame(48'h0A1, 48'h05A, 5'd2, 1'b1);
		sendFrame(48'h05A, 48'h0B1, 5'd4, 1'b1);
		repeat (3) @(posedge clk);
		chk(lastMask, 26'h200);
		axWr(ADDR_KEY_LO, 32'hF1, RESP_OKAY);
		axWr(ADDR_CMD, 32'h401, RESP_OKAY);
		n = gotCount;
		sendFrame(48'h0F1, 48'h0A1, 5'd1, 1'b1);
		repeat (3) @(posedge clk);
		chk(gotCount - n, 16'h0);
		axRd(ADDR_DROP_CNT, 32'h3, RESP_OKAY);
		axRd(ADDR_FWD_CNT, 32'h5, RESP_OKAY);
		stall <= 1'b1;
		n = gotCount;
		sendFrame(48'h0B1, 48'h0A1, 5'd2, 1'b1);
		sendFrame(48'h0B1, 48'h0A1, 5'd6, 1'b1);
		chk(rxReady, 1'b0);
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		// The station was last learned on port 4.
		chk({gotCount - n, lastId, lastMask}, {16'h2, rxFrameId, 26'h10});
		askMgmt(32'hC0A80108, 1'b1);
		axWr(ADDR_KEY_LO, 32'hC0A80107, RESP_OKAY);
		axWr(ADDR_CMD, 32'h412, RESP_OKAY);
		axWr(ADDR_CTRL, 32'h7D, RESP_OKAY);
		askMgmt(32'hC0A80107, 1'b1);
		askMgmt(32'hC0A80108, 1'b0);
		for (int i = 0; i < 5; i++) begin
			link(5'h1F >> (4 - i), neg_mode_type'(i + 1));
		end
		axRd(ADDR_STATUS, 32'h5, RESP_OKAY);
		// VLAN-aware lookups: entries keyed on VID 0 miss in VLAN 5.
		axWr(ADDR_CTRL, 32'h7F, RESP_OKAY);
		rxVid <= 12'h005;
		n = gotCount;
		sendFrame(48'h0F1, 48'h0D1, 5'd0, 1'b1);
		sendFrame(48'h05A, 48'h0D1, 5'd0, 1'b1);
		repeat (3) @(posedge clk);
		chk({gotCount - n, lastMask}, {16'h2, 26'h3FFFFFE});
		// Deleting the filter entry lets its address through again.
		axWr(ADDR_CMD, 32'h001, RESP_OKAY);
		rxVid <= 12'h000;
		sendFrame(48'h0F1, 48'h0D1, 5'd1, 1'b1);
		repeat (3) @(posedge clk);
		chk({gotCount - n, lastMask}, {16'h3, 26'h3FFFFFD});
		endOfTest();
	end
endmodule // l2_address_table_forwarder_tb
`default_nettype wire
